// File: inc/e1_pkg.sv
// shared constants for the e1 channel controller
package e1_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CHAN = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam int CTRL_SRST = 0;
  localparam int CTRL_CODE = 2;
  localparam int CTRL_POL = 3;
  localparam int CTRL_TXE = 4;
  localparam int CTRL_RXE = 5;
  localparam int CTRL_RAIL = 7;
  localparam logic [7:0] CTRL_WMASK = 8'hBC;
  localparam int CHAN_ONES = 0;
  localparam int CHAN_RMT_LOOP = 1;
  localparam int CHAN_ANA_LOOP = 2;
  localparam int CHAN_SHUT = 3;
  localparam int STAT_TX_OK = 0;
  localparam int STAT_DMF = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] CHAN_RST = 4'h0;
  localparam int CLK_NS = 5;
  localparam int HWRST_NS = 10000;
  localparam logic [11:0] HWRST_CYC = 12'(HWRST_NS / CLK_NS);
  localparam int TXLOSS_NS = 10000;
  localparam logic [11:0] TXLOSS_CYC = 12'(TXLOSS_NS / CLK_NS);
  localparam logic [7:0] DMON_LIMIT = 8'h80;
  localparam logic [1:0] SYM_ZERO = 2'h0;
  localparam logic [1:0] SYM_MARK = 2'h1;
  localparam logic [1:0] SYM_VIOL = 2'h2;
  typedef enum logic [1:0] {APB_IDLE = 2'b01, APB_RESP = 2'b10} apb_e;
endpackage : e1_pkg

// File: hdl/bit_sync.sv
// two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/10ps
module bit_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;
endmodule : bit_sync

// File: hdl/line_encoder.sv
// ami / hdb3 line encoder with four-bit look-ahead
`timescale 1ns/10ps
module line_encoder (
  // clock and clear
  input wire logic clk_in,
  input wire logic clr_in,
  // bit stream
  input wire logic stb_in,
  input wire logic bit_in,
  input wire logic hdb3_in,
  // rails
  output logic plus_out,
  output logic minus_out
);
  logic [1:0] pipe_q [0:3];
  logic [1:0] pipe_d [0:3];
  logic par_q;
  logic par_d;
  logic pol_q;
  logic pol_d;
  logic p_q;
  logic p_d;
  logic m_q;
  logic m_d;
  logic sub;

  // every mode runs through the same four-bit delay, so latency is fixed
  always_comb begin
    pipe_d = pipe_q;
    par_d = par_q;
    pol_d = pol_q;
    p_d = p_q;
    m_d = m_q;
    sub = hdb3_in && !bit_in && pipe_q[0] == e1_pkg::SYM_ZERO &&
          pipe_q[1] == e1_pkg::SYM_ZERO && pipe_q[2] == e1_pkg::SYM_ZERO;
    if (stb_in) begin
      pipe_d[1] = pipe_q[0];
      pipe_d[2] = pipe_q[1];
      pipe_d[3] = pipe_q[2];
      pipe_d[0] = bit_in ? e1_pkg::SYM_MARK : e1_pkg::SYM_ZERO;
      if (sub) begin
        pipe_d[0] = e1_pkg::SYM_VIOL; // R14
        if (!par_q) begin
          pipe_d[3] = e1_pkg::SYM_MARK; // R15
        end
        par_d = 1'b0;
      end else if (bit_in) begin
        par_d = !par_q;
      end
      case (pipe_q[3])
        e1_pkg::SYM_MARK: begin
          pol_d = !pol_q; // R20
          p_d = !pol_q;
          m_d = pol_q;
        end
        e1_pkg::SYM_VIOL: begin
          p_d = pol_q; // R14
          m_d = !pol_q;
        end
        default: begin
          p_d = 1'b0; // R20
          m_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (clr_in) begin
      pipe_q <= '{default: e1_pkg::SYM_ZERO};
      par_q <= 1'b0;
      pol_q <= 1'b0;
      p_q <= 1'b0;
      m_q <= 1'b0;
    end else begin
      pipe_q <= pipe_d;
      par_q <= par_d;
      pol_q <= pol_d;
      p_q <= p_d;
      m_q <= m_d;
    end
  end

  assign plus_out = p_q;
  assign minus_out = m_q;

  default clocking @(posedge clk_in); endclocking
  default disable iff (clr_in);

  property p_no_both;
    !(p_q && m_q);
  endproperty
  a_no_both: assert property (p_no_both) else $error("both rails high"); // R20

  property p_viol_same;
    stb_in && pipe_q[3] == e1_pkg::SYM_VIOL |=> p_q == pol_q && m_q != pol_q;
  endproperty
  a_viol_same: assert property (p_viol_same) else $error("bad violation"); // R14

  property p_b00v;
    stb_in && sub && !par_q |=> pipe_q[3] == e1_pkg::SYM_MARK && !par_q;
  endproperty
  a_b00v: assert property (p_b00v) else $error("missing B pulse"); // R15
endmodule : line_encoder

// File: hdl/e1_chan_ctrl.sv
// e1 channel control: apb registers, clock selection, line paths
// Behaviour
// [R1] analog loop feeds tx line into receiver
// [R2] reset pin low over 10 us resets all
// [R3] soft reset clears channel state, keeps registers
// [R4] polarity bit inverts rx data and violation
// [R5] polarity bit inverts tx inputs, host only
// [R6] rx edge bit picks output retiming edge
// [R7] tx edge bit picks tx sampling edge
// [R8] hardware edge pin serves both clocks
// [R9] framer drives single rail on pos input
// [R10] all ones sends marks, ignores inputs
// [R11] all ones falls back to reference clock
// [R12] remote loop wins over all ones
// [R13] encoder single rail; code bit hdb3/ami
// [R14] four zeros become 000V or B00V
// [R15] odd B count between violations
// [R16] 128 quiet bits set monitor flag, interrupt
// [R17] shutdown disables and floats tx line
// [R18] hardware pin shuts each transmitter down
// [R19] other side never enables both loopbacks
// [R20] ami marks alternate, zeros send nothing
`timescale 1ns/10ps
module e1_chan_ctrl (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // mode and hardware-mode pins
  input wire logic HOST_MODE_IN,
  input wire logic HW_RESET_N_IN,
  input wire logic HW_CLOCK_EDGE_PIN_IN,
  input wire logic HW_RAIL_FORMAT_IN,
  input wire logic HW_CODE_SELECT_IN,
  input wire logic HW_TX_SHUTDOWN_IN,
  input wire logic HW_ALL_ONES_IN,
  input wire logic HW_REMOTE_LOOP_IN,
  input wire logic HW_ANALOG_LOOP_IN,
  // clocks from outside
  input wire logic TX_LINE_CLOCK_IN,
  input wire logic RX_RECOVERED_CLOCK_IN,
  input wire logic REF_CLOCK_IN,
  // terminal side
  input wire logic TX_POS_DATA_IN,
  input wire logic TX_NEG_DATA_IN,
  output logic RX_POS_DATA_OUT,
  output logic RX_NEG_DATA_OUT,
  // line side
  input wire logic RX_LINE_PLUS_IN,
  input wire logic RX_LINE_MINUS_IN,
  output logic TX_LINE_PLUS_OUT,
  output logic TX_LINE_MINUS_OUT,
  output logic TX_LINE_OE_OUT,
  // interrupt
  output logic INT_OUT
);
  logic [15:0] pins_s;
  logic hwrst_n_s;
  logic edge_s;
  logic rail_s;
  logic code_s;
  logic shut_s;
  logic ones_s;
  logic rmt_loop_s;
  logic ana_loop_s;
  logic host;
  logic txc_s;
  logic rxc_s;
  logic ref_s;
  logic txpos_s;
  logic tx_neg_data_in_s;
  logic rxlp_s;
  logic rxlm_s;

  // every pin and foreign clock passes two flops before use
  bit_sync #(.W(16), .RST_VAL(16'h8000)) u_sync (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .d_in({HW_RESET_N_IN, HW_CLOCK_EDGE_PIN_IN, HW_RAIL_FORMAT_IN,
           HW_CODE_SELECT_IN, HW_TX_SHUTDOWN_IN, HW_ALL_ONES_IN,
           HW_REMOTE_LOOP_IN, HW_ANALOG_LOOP_IN, HOST_MODE_IN,
           TX_LINE_CLOCK_IN, RX_RECOVERED_CLOCK_IN, REF_CLOCK_IN,
           TX_POS_DATA_IN, TX_NEG_DATA_IN, RX_LINE_PLUS_IN,
           RX_LINE_MINUS_IN}),
    .q_out(pins_s)
  );
  assign {hwrst_n_s, edge_s, rail_s, code_s, shut_s, ones_s, rmt_loop_s,
          ana_loop_s, host, txc_s, rxc_s, ref_s, txpos_s, tx_neg_data_in_s,
          rxlp_s, rxlm_s} = pins_s;

  // hardware reset pin qualifier
  logic [11:0] hwc_q;
  logic [11:0] hwc_d;
  logic hwr_q;
  logic hwr_d;
  logic rst_all;
  logic srst_q;
  logic rst_ch;

  always_comb begin
    hwc_d = 12'h000;
    hwr_d = 1'b0;
    if (!hwrst_n_s) begin
      hwc_d = (hwc_q == e1_pkg::HWRST_CYC) ? hwc_q : hwc_q + 12'h001;
      hwr_d = (hwc_q == e1_pkg::HWRST_CYC); // R2
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      hwc_q <= 12'h000;
      hwr_q <= 1'b0;
    end else begin
      hwc_q <= hwc_d;
      hwr_q <= hwr_d;
    end
  end

  assign rst_all = RST_IN || hwr_q; // R2
  assign rst_ch = rst_all || srst_q; // R3

  // register file and apb slave
  e1_pkg::apb_e st_q;
  e1_pkg::apb_e st_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [3:0] chan_q;
  logic [3:0] chan_d;
  logic dmf_q;
  logic dmf_d;
  logic srst_d;
  logic rdy_q;
  logic rdy_d;
  logic err_q;
  logic err_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] rd_word;
  logic hit;
  logic dmon_hit;
  logic txpr_q;

  always_comb begin
    rd_word = 32'h0000_0000;
    hit = 1'b1;
    case (PADDR_IN)
      e1_pkg::OFS_CTRL: rd_word[7:0] = ctrl_q;
      e1_pkg::OFS_CHAN: rd_word[3:0] = chan_q;
      e1_pkg::OFS_STAT: begin
        rd_word[e1_pkg::STAT_DMF] = dmf_q;
        rd_word[e1_pkg::STAT_TX_OK] = txpr_q;
      end
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    st_d = st_q;
    rdy_d = 1'b0;
    err_d = 1'b0;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    chan_d = chan_q;
    dmf_d = dmf_q;
    srst_d = 1'b0;
    case (st_q)
      e1_pkg::APB_IDLE: begin
        if (PSEL_IN && PENABLE_IN) begin
          st_d = e1_pkg::APB_RESP;
          rdy_d = 1'b1;
          err_d = !hit;
          rdata_d = rd_word;
        end
      end
      e1_pkg::APB_RESP: begin
        st_d = e1_pkg::APB_IDLE;
        if (PSEL_IN && PENABLE_IN && PWRITE_IN) begin
          case (PADDR_IN)
            e1_pkg::OFS_CTRL: begin
              ctrl_d = PWDATA_IN[7:0] & e1_pkg::CTRL_WMASK;
              srst_d = PWDATA_IN[e1_pkg::CTRL_SRST]; // R3
            end
            e1_pkg::OFS_CHAN: chan_d = PWDATA_IN[3:0];
            e1_pkg::OFS_STAT: begin
              if (PWDATA_IN[e1_pkg::STAT_DMF]) begin
                dmf_d = 1'b0;
              end
            end
            default: ;
          endcase
        end
      end
      default: st_d = e1_pkg::APB_IDLE;
    endcase
    // a new quiet detection beats a clear in the same cycle
    if (dmon_hit) begin
      dmf_d = 1'b1; // R16
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (rst_all) begin
      st_q <= e1_pkg::APB_IDLE;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      ctrl_q <= e1_pkg::CTRL_RST;
      chan_q <= e1_pkg::CHAN_RST;
      dmf_q <= 1'b0;
      srst_q <= 1'b0;
    end else begin
      st_q <= st_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      chan_q <= chan_d;
      dmf_q <= dmf_d;
      srst_q <= srst_d;
    end
  end

  // mode selection, host register or hardware pin
  logic single;
  logic pol;
  logic hdb3;
  logic tx_rise_sel;
  logic rx_rise_sel;
  logic ones;
  logic rmt_loop;
  logic ana_loop;
  logic shut;
  logic ones_sel;
  logic use_enc;

  assign single = host ? ctrl_q[e1_pkg::CTRL_RAIL] : rail_s;
  assign pol = host && ctrl_q[e1_pkg::CTRL_POL]; // R4 R5
  assign hdb3 = !(host ? ctrl_q[e1_pkg::CTRL_CODE] : code_s); // R13
  assign tx_rise_sel = host ? ctrl_q[e1_pkg::CTRL_TXE] : edge_s; // R7 R8
  assign rx_rise_sel = host ? ctrl_q[e1_pkg::CTRL_RXE] : edge_s; // R6 R8
  assign ones = host ? chan_q[e1_pkg::CHAN_ONES] : ones_s;
  assign rmt_loop = host ? chan_q[e1_pkg::CHAN_RMT_LOOP] : rmt_loop_s;
  assign ana_loop = host ? chan_q[e1_pkg::CHAN_ANA_LOOP] : ana_loop_s;
  assign shut = host ? chan_q[e1_pkg::CHAN_SHUT] : shut_s; // R17 R18
  assign ones_sel = ones && !rmt_loop; // R12
  assign use_enc = ones_sel || (single && !rmt_loop); // R10 R13

  // clock edge detection and transmit clock presence
  logic txc_p_q;
  logic rxc_p_q;
  logic ref_p_q;
  logic [11:0] txl_q;
  logic [11:0] txl_d;
  logic txpr_d;
  logic tx_stb;
  logic rx_stb;
  logic ref_rise;
  logic tim_stb;

  always_comb begin
    tx_stb = tx_rise_sel ? (txc_s && !txc_p_q) : (!txc_s && txc_p_q); // R7
    // outputs change on the edge opposite the one that validates them
    rx_stb = rx_rise_sel ? (!rxc_s && rxc_p_q) : (rxc_s && !rxc_p_q); // R6
    ref_rise = ref_s && !ref_p_q;
    txl_d = txl_q;
    if (txc_s != txc_p_q) begin
      txl_d = 12'h000;
    end else if (txl_q != e1_pkg::TXLOSS_CYC) begin
      txl_d = txl_q + 12'h001;
    end
    txpr_d = (txl_d != e1_pkg::TXLOSS_CYC); // R11
    if (rmt_loop) begin
      tim_stb = rx_stb;
    end else if (ones_sel && !txpr_q) begin
      tim_stb = ref_rise; // R11
    end else begin
      tim_stb = tx_stb;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (rst_ch) begin
      txc_p_q <= 1'b0;
      rxc_p_q <= 1'b0;
      ref_p_q <= 1'b0;
      txl_q <= 12'h000;
      txpr_q <= 1'b1;
    end else begin
      txc_p_q <= txc_s;
      rxc_p_q <= rxc_s;
      ref_p_q <= ref_s;
      txl_q <= txl_d;
      txpr_q <= txpr_d;
    end
  end

  // transmit path and driver monitor
  logic enc_bit;
  logic enc_p;
  logic enc_m;
  logic rlp_q;
  logic rlm_q;
  logic dp_q;
  logic dp_d;
  logic dm_q;
  logic dm_d;
  logic txp_q;
  logic txp_d;
  logic txm_q;
  logic txm_d;
  logic oe_q;
  logic prv_p_q;
  logic prv_m_q;
  logic [7:0] dmc_q;
  logic [7:0] dmc_d;
  logic int_q;

  // only the pos input feeds the encoder; the neg input is unused then
  assign enc_bit = ones_sel || (txpos_s ^ pol); // R5 R9 R10

  line_encoder u_enc (
    .clk_in(CLK_IN),
    .clr_in(rst_ch),
    .stb_in(tim_stb && use_enc && !shut),
    .bit_in(enc_bit),
    .hdb3_in(hdb3 && !ones_sel),
    .plus_out(enc_p),
    .minus_out(enc_m)
  );

  always_comb begin
    dp_d = dp_q;
    dm_d = dm_q;
    if (tim_stb) begin
      dp_d = rmt_loop ? rlp_q : (txpos_s ^ pol); // R12 R5
      dm_d = rmt_loop ? rlm_q : (tx_neg_data_in_s ^ pol);
    end
    txp_d = use_enc ? enc_p : dp_q;
    txm_d = use_enc ? enc_m : dm_q;
    if (shut) begin
      txp_d = 1'b0; // R17 R18
      txm_d = 1'b0;
    end
    dmc_d = dmc_q;
    if (!host || shut || txp_q != prv_p_q || txm_q != prv_m_q) begin
      dmc_d = 8'h00; // R16
    end else if (tim_stb && dmc_q <= e1_pkg::DMON_LIMIT) begin
      dmc_d = dmc_q + 8'h01;
    end
  end

  assign dmon_hit = host && dmc_q > e1_pkg::DMON_LIMIT; // R16

  always_ff @(posedge CLK_IN) begin
    if (rst_ch) begin
      dp_q <= 1'b0;
      dm_q <= 1'b0;
      txp_q <= 1'b0;
      txm_q <= 1'b0;
      oe_q <= 1'b0;
      prv_p_q <= 1'b0;
      prv_m_q <= 1'b0;
      dmc_q <= 8'h00;
      int_q <= 1'b0;
    end else begin
      dp_q <= dp_d;
      dm_q <= dm_d;
      txp_q <= txp_d;
      txm_q <= txm_d;
      oe_q <= !shut; // R17
      prv_p_q <= txp_q;
      prv_m_q <= txm_q;
      dmc_q <= dmc_d;
      int_q <= host && dmf_q; // R16
    end
  end

  // receive path; violation flagging assumes ami-style decoding
  logic src_p;
  logic src_m;
  logic rx_data;
  logic code_viol;
  logic lpol_q;
  logic lpol_d;
  logic rlp_d;
  logic rlm_d;
  logic rxp_q;
  logic rxp_d;
  logic rxn_q;
  logic rxn_d;

  always_comb begin
    src_p = ana_loop ? txp_q : rxlp_s; // R1
    src_m = ana_loop ? txm_q : rxlm_s;
    rx_data = src_p || src_m;
    code_viol = (src_p && lpol_q) || (src_m && !lpol_q);
    lpol_d = lpol_q;
    rlp_d = rlp_q;
    rlm_d = rlm_q;
    rxp_d = rxp_q;
    rxn_d = rxn_q;
    if (rx_stb) begin
      rlp_d = src_p;
      rlm_d = src_m;
      if (rx_data) begin
        lpol_d = src_p;
      end
      rxp_d = (single ? rx_data : src_p) ^ pol; // R4
      rxn_d = (single ? code_viol : src_m) ^ pol; // R4
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (rst_ch) begin
      lpol_q <= 1'b0;
      rlp_q <= 1'b0;
      rlm_q <= 1'b0;
      rxp_q <= 1'b0;
      rxn_q <= 1'b0;
    end else begin
      lpol_q <= lpol_d;
      rlp_q <= rlp_d;
      rlm_q <= rlm_d;
      rxp_q <= rxp_d;
      rxn_q <= rxn_d;
    end
  end

  assign PRDATA_OUT = rdata_q;
  assign PREADY_OUT = rdy_q;
  assign PSLVERR_OUT = err_q;
  assign TX_LINE_PLUS_OUT = txp_q;
  assign TX_LINE_MINUS_OUT = txm_q;
  assign TX_LINE_OE_OUT = oe_q;
  assign RX_POS_DATA_OUT = rxp_q;
  assign RX_NEG_DATA_OUT = rxn_q;
  assign INT_OUT = int_q;

  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  property p_hw_reset;
    hwr_q |=> ctrl_q == e1_pkg::CTRL_RST && chan_q == e1_pkg::CHAN_RST;
  endproperty
  a_hw_reset: assert property (p_hw_reset) else $error("hw reset"); // R2

  property p_srst_keep;
    srst_q |=> $stable(ctrl_q) && $stable(chan_q) && dmc_q == 8'h00;
  endproperty
  a_srst_keep: assert property (p_srst_keep) else $error("soft reset"); // R3

  property p_shut;
    shut |=> !oe_q && !txp_q && !txm_q;
  endproperty
  a_shut: assert property (p_shut) else $error("line not floated"); // R17

  property p_rmt_prio;
    rmt_loop && ones && rx_stb && !rst_ch |=>
      dp_q == $past(rlp_q) && dm_q == $past(rlm_q);
  endproperty
  a_rmt_prio: assert property (p_rmt_prio) else $error("loop prio"); // R12

  property p_ones_ref;
    ones_sel && !txpr_q |-> tim_stb == ref_rise && enc_bit;
  endproperty
  a_ones_ref: assert property (p_ones_ref) else $error("all ones"); // R11

  sequence s_quiet;
    host && !shut && dmc_q > e1_pkg::DMON_LIMIT;
  endsequence
  sequence s_flag;
    dmf_q ##1 INT_OUT;
  endsequence
  property p_dmon;
    s_quiet |=> s_flag;
  endproperty
  a_dmon: assert property (p_dmon) else $error("monitor flag"); // R16

  property p_rx_pol;
    rx_stb && single && pol && !rst_ch |=>
      RX_POS_DATA_OUT == !$past(rx_data);
  endproperty
  a_rx_pol: assert property (p_rx_pol) else $error("rx polarity"); // R4

  // a soft or pin reset clears the rail without a strobe
  property p_rx_edge;
    $changed(rxp_q) |-> $past(rx_stb) || $past(rst_ch);
  endproperty
  a_rx_edge: assert property (p_rx_edge) else $error("rx retime"); // R6

  property p_ana_loop;
    ana_loop && rx_stb |=> rlp_q == $past(txp_q) && rlm_q == $past(txm_q);
  endproperty
  a_ana_loop: assert property (p_ana_loop) else $error("analog loop"); // R1
endmodule : e1_chan_ctrl

// File: tb/e1_framer_model.sv
// framer and line model facing the e1 channel
`timescale 1ns/10ps
module e1_framer_model (
  // control from the bench
  input wire logic run_in,
  input wire logic [31:0] pat_in,
  // terminal side
  output logic tx_clk_out,
  output logic tx_pos_out,
  output logic tx_neg_out,
  // line side
  output logic rx_clk_out,
  output logic rx_plus_out,
  output logic rx_minus_out
);
  int idx = 0;
  // link clock stands still while no frame runs
  initial begin
    tx_clk_out = 1'b0;
    tx_pos_out = 1'b0;
    tx_neg_out = 1'b0;
    forever begin
      #24;
      if (run_in) tx_clk_out = ~tx_clk_out;
    end
  end
  // new bit after each falling edge, settled at the rising sample edge
  always @(negedge tx_clk_out) begin
    tx_pos_out <= pat_in[idx];
    // unused rail keeps moving so a design that reads it is caught
    tx_neg_out <= ~tx_neg_out;
    idx <= (idx + 1) % 32;
  end
  // recovered clock at the bit rate; idle line shows only spaces
  assign rx_clk_out = tx_clk_out;
  assign rx_plus_out = 1'b0;
  assign rx_minus_out = 1'b0;
endmodule : e1_framer_model

// File: tb/testbench.sv
// self-checking bench for the e1 channel controller
`timescale 1ns/10ps
module testbench;
  typedef struct {
    logic [7:0] a;
    logic [31:0] w;
    logic [31:0] x;
    logic e;
  } row_s;
  logic clk, rst, psel, pen, pwr, host, hwrst_n, hw_edge, hw_rail, hw_code;
  logic hw_shut, hw_ones, hw_rmt, hw_ana, ref_clk, run, pready, pslverr;
  logic rxp, rxn, txp, txm, oe, irq, tclk, tpos, tneg, rclk, rlp, rlm, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, pat;
  logic [1:0] syms [0:63];
  int err_count, compares, v, b, m, r;
  row_s rows [0:4] = '{
    '{8'h00, 32'h000000FF, 32'h000000BC, 1'b0},
    '{8'h04, 32'h0000000B, 32'h0000000B, 1'b0},
    '{8'h04, 32'h00000000, 32'h00000000, 1'b0},
    '{8'h0C, 32'hFFFFFFFF, 32'h00000000, 1'b1},
    '{8'h00, 32'h00000031, 32'h00000030, 1'b0}};

  e1_chan_ctrl e1_chan_ctrl_inst (.CLK_IN(clk), .RST_IN(rst),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .HOST_MODE_IN(host), .HW_RESET_N_IN(hwrst_n),
    .HW_CLOCK_EDGE_PIN_IN(hw_edge), .HW_RAIL_FORMAT_IN(hw_rail),
    .HW_CODE_SELECT_IN(hw_code), .HW_TX_SHUTDOWN_IN(hw_shut),
    .HW_ALL_ONES_IN(hw_ones), .HW_REMOTE_LOOP_IN(hw_rmt),
    .HW_ANALOG_LOOP_IN(hw_ana), .TX_LINE_CLOCK_IN(tclk),
    .RX_RECOVERED_CLOCK_IN(rclk), .REF_CLOCK_IN(ref_clk),
    .TX_POS_DATA_IN(tpos), .TX_NEG_DATA_IN(tneg), .RX_POS_DATA_OUT(rxp),
    .RX_NEG_DATA_OUT(rxn), .RX_LINE_PLUS_IN(rlp), .RX_LINE_MINUS_IN(rlm),
    .TX_LINE_PLUS_OUT(txp), .TX_LINE_MINUS_OUT(txm), .TX_LINE_OE_OUT(oe),
    .INT_OUT(irq));
  e1_framer_model e1_framer_model_inst (.run_in(run), .pat_in(pat),
    .tx_clk_out(tclk), .tx_pos_out(tpos), .tx_neg_out(tneg),
    .rx_clk_out(rclk), .rx_plus_out(rlp), .rx_minus_out(rlm));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    ref_clk = 1'b0;
    forever #244 ref_clk = ~ref_clk;
  end

  task report_and_stop;
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer: request held until pready is seen high at a rising
  // edge; data and error are taken at that edge, then released
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) err_count++;
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  // loopbacks are never both set by this controller
  task setcfg(input logic [7:0] c, input logic [3:0] ch);
    apb(1'b1, 8'h00, {24'h0, c});
    apb(1'b1, 8'h04, {28'h0, ch});
    repeat (12) @(posedge tclk);
  endtask : setcfg

  // collect line symbols once a bit; marks of equal sign in a row are
  // violations, and between two of them the pulse count must be odd
  task grab(input int n);
    int last, cnt, zr, seen;
    last = 0;
    cnt = 0;
    zr = 0;
    seen = 0;
    v = 0;
    b = 0;
    m = 0;
    r = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge tclk);
      syms[i] = {txp, txm};
      if (rxp === 1'b1) r++;
      if (syms[i] === 2'b11) b++;
      if (syms[i] === 2'b00) zr++;
      else begin
        zr = 0;
        m++;
        if (int'(syms[i]) == last) begin
          if (seen == 1 && cnt % 2 == 0) b++;
          seen = 1;
          cnt = 0;
          v++;
        end else cnt++;
        last = int'(syms[i]);
      end
      if (zr >= 4) b++;
    end
  endtask : grab

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    host = 1'b1;
    hwrst_n = 1'b1;
    hw_edge = 1'b1;
    hw_rail = 1'b1;
    hw_code = 1'b1;
    hw_shut = 1'b0;
    hw_ones = 1'b0;
    hw_rmt = 1'b0;
    hw_ana = 1'b0;
    run = 1'b0;
    pat = 32'h0;
    err_count = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    run <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    chk({rxp, irq}, 2'b00);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      chk(e, rows[i].e);
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].x);
      chk(e, rows[i].e);
    end
    setcfg(8'hB4, 4'h1);
    grab(24);
    chk(m, 24);
    chk(v, 0);
    setcfg(8'hBC, 4'h0);
    grab(24);
    chk(m, 24);
    pat <= 32'h00000001;
    setcfg(8'hB0, 4'h0);
    grab(64);
    chk(b, 0);
    chk(v > 0, 1);
    setcfg(8'hB4, 4'h0);
    grab(64);
    chk(v, 0);
    chk(m, 2);
    pat <= 32'h0;
    setcfg(8'hB4, 4'h3);
    grab(24);
    chk(m, 0);
    setcfg(8'hB4, 4'h5);
    grab(24);
    chk(m, 24);
    chk(r, 24);
    setcfg(8'hB0, 4'h0);
    chk({rxp, rxn}, 2'b00);
    setcfg(8'hB8, 4'h0);
    chk({rxp, rxn}, 2'b11);
    setcfg(8'hB4, 4'h0);
    repeat (135) @(posedge tclk);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd[7], 1'b1);
    chk(rd[0], 1'b1);
    chk(irq, 1'b1);
    setcfg(8'hB4, 4'h1);
    apb(1'b1, 8'h08, 32'h80);
    apb(1'b0, 8'h08, 32'h0);
    chk({rd[7], irq}, 2'b00);
    setcfg(8'hB4, 4'h8);
    chk(oe, 1'b0);
    setcfg(8'hB4, 4'h1);
    chk(oe, 1'b1);
    // held well past the 2000-cycle threshold plus synchroniser delay
    hwrst_n <= 1'b0;
    repeat (2010) @(posedge clk);
    hwrst_n <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    host <= 1'b0;
    hw_shut <= 1'b1;
    repeat (10) @(posedge clk);
    chk(oe, 1'b0);
    hw_shut <= 1'b0;
    hw_ones <= 1'b1;
    repeat (12) @(posedge tclk);
    grab(24);
    chk(v, 0);
    chk(m, 24);
    // link clock stopped: all ones must go on, paced by the reference
    run <= 1'b0;
    repeat (2100) @(posedge clk);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd[0], 1'b0);
    @(posedge ref_clk);
    syms[0] = {txp, txm};
    b = 0;
    for (int i = 1; i < 9; i++) begin
      @(posedge ref_clk);
      syms[i] = {txp, txm};
      if (syms[i] !== ~syms[i - 1]) b++;
    end
    chk(b, 0);
    report_and_stop;
  end

  // the sequence needs about 11000 cycles; nearly four times that means a hang
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    report_and_stop;
  end
endmodule : testbench
